// ### i2c_irq_map.svh
/*
  register offsets, field positions and reset values of the i2c
  interrupt gating block. assumes nothing; definitions only.
*/
`ifndef I2C_IRQ_MAP_SVH
`define I2C_IRQ_MAP_SVH

`define I2C_FLAGS_OFS      8'h00
`define I2C_IRQ_ENABLE_OFS 8'h02

`define I2C_IRQ_ENABLE_RST 16'h0000
`define I2C_FLAGS_RST      16'h0000
`define I2C_IRQ_VALID_MASK 16'h0bff

`define BIT_START      0
`define BIT_TX_DONE    1
`define BIT_RX_READY   2
`define BIT_STRETCH    3
`define BIT_TIMEOUT    4
`define BIT_ADDR_MATCH 5
`define BIT_ARB_LOST   6
`define BIT_NACK       7
`define BIT_GENCALL    8
`define BIT_OVERRUN    9
`define BIT_STOP       11

`endif

// ### i2c_irq_pkg.sv
/*
  types shared by the i2c interrupt gating block.
  assumes a 16-bit register data path.
*/
package i2c_irq_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  addr_t;
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_FLAGS,
    SEL_ENABLE
  } reg_sel_t;
endpackage

// ### event_flag_bank.sv
/*
  latched i2c event flags, one flip-flop per valid bit.
  assumes set pulses come from the i2c engine on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "i2c_irq_map.svh"

module event_flag_bank #(
  parameter int          W     = 16,
  parameter logic [15:0] VALID = `I2C_IRQ_VALID_MASK
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  // hardware events and software access
  input  wire logic [W-1:0] i_set,
  input  wire logic         i_wr,
  input  wire logic [W-1:0] i_wdata,
  input  wire logic         i_rd_clear,
  // flag state
  output var  logic [W-1:0] o_flags
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_flag
      if (VALID[i] == 1'b0)
      begin : g_rsvd
        assign o_flags[i] = 1'b0;
      end
      else if (i == `BIT_OVERRUN)
      begin : g_ovr
        // set wins; only a buffer read clears, writing zero does not
        always_ff @(posedge i_ref_clk)
          if (i_rst)
            o_flags[i] <= 1'b0;
          else if (i_set[i] || (i_wr && i_wdata[i]))
            o_flags[i] <= 1'b1;
          else if (i_rd_clear)
            o_flags[i] <= 1'b0;
      end
      else
      begin : g_std
        // set wins over a software clear in the same cycle
        always_ff @(posedge i_ref_clk)
          if (i_rst)
            o_flags[i] <= 1'b0;
          else if (i_set[i])
            o_flags[i] <= 1'b1;
          else if (i_wr)
            o_flags[i] <= i_wdata[i];
      end
    end
  endgenerate
endmodule // event_flag_bank
`default_nettype wire

// ### irq_request_gate.sv
/*
  and-or gating of event flags by their enables into one request.
  assumes both inputs come from flip-flops.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_request_gate #(
  parameter int W = 16
) (
  // flags and enables
  input  wire logic [W-1:0] i_flags,
  input  wire logic [W-1:0] i_enable,
  // level request
  output var  logic         o_irq
);
  // purely combinational so an enable write acts in the cycle after its strobe, once the register has taken it
  assign o_irq = |(i_flags & i_enable);
endmodule // irq_request_gate
`default_nettype wire

// ### i2c_interrupt_enable_gating.sv
/*
  i2c interrupt enable register, event flag register and gating of
  the cpu interrupt request.
  assumes a plain register port (read data one cycle later) and event
  set pulses from the i2c engine, all on i_ref_clk.
*/
// How it works
// RL1: enable register is 16-bit read/write, zero after any reset.
// RL2: bit 0 gates start-detected flag into the cpu request.
// RL3: bit 1 gates transmit-complete flag into the cpu request.
// RL4: bit 2 gates receive-ready flag into the cpu request.
// RL5: bit 3 gates clock-stretch flag into the cpu request.
// RL6: bit 4 gates bus-timeout flag into the cpu request.
// RL7: bit 5 gates own-address match flag into the cpu request.
// RL8: bit 6 gates arbitration-loss flag into the cpu request.
// RL9: bit 7 gates nack-received flag into the cpu request.
// RL10: bit 8 gates general-call flag, set only while recognition enabled.
// RL11: bit 9 gates receiver-overrun flag into the cpu request.
// RL12: bit 11 gates stop-detected flag into the cpu request.
// RL13: enable bits 10 and 15 to 12 always read zero.
// RL14: software clears each flag except overrun by writing zero; flag holds till then.
// RL15: buffer read clears overrun; writing zero to it does not.
// RL16: one level request, or of each flag anded with its enable.
// RL17: enable change reaches the request within one clock.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_irq_map.svh"

module i2c_interrupt_enable_gating (
  // clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  // register port
  input  wire i2c_irq_pkg::addr_t i_addr,
  input  wire i2c_irq_pkg::word_t i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output var  i2c_irq_pkg::word_t o_rdata,
  // i2c engine events
  input  wire i2c_irq_pkg::word_t i_event_set,
  input  wire logic               i_gencall_recognize_en,
  input  wire logic               i_data_buffer_read,
  // state and request
  output var  i2c_irq_pkg::word_t o_flags,
  output var  i2c_irq_pkg::word_t o_irq_enable,
  output var  logic               o_irq
);
  import i2c_irq_pkg::*;

  localparam word_t VALID = `I2C_IRQ_VALID_MASK;

  function automatic reg_sel_t decode(input addr_t a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a == `I2C_FLAGS_OFS)
      s = SEL_FLAGS;
    else if (a == `I2C_IRQ_ENABLE_OFS)
      s = SEL_ENABLE;
    return s;
  endfunction

  logic  wr_flags;
  logic  wr_enable;
  word_t set_vec;
  word_t irq_en;
  word_t flags;

  assign wr_flags  = i_wr && (decode(i_addr) == SEL_FLAGS);
  assign wr_enable = i_wr && (decode(i_addr) == SEL_ENABLE);

  // RL10 recognition gates set
  always_comb
  begin
    set_vec = i_event_set & VALID;
    set_vec[`BIT_GENCALL] = i_event_set[`BIT_GENCALL] && i_gencall_recognize_en;
  end

  // RL1 enable register
  // RL13 reserved bits dropped
  always_ff @(posedge i_ref_clk)
    if (i_rst)
      irq_en <= `I2C_IRQ_ENABLE_RST;
    else if (wr_enable)
      irq_en <= i_wdata & VALID;

  // read data stand for exactly one cycle; unmapped reads give zero
  always_ff @(posedge i_ref_clk)
    if (i_rst)
      o_rdata <= '0;
    else if (i_rd)
    begin
      unique case (decode(i_addr))
        SEL_FLAGS:  o_rdata <= flags;
        SEL_ENABLE: o_rdata <= irq_en;
        SEL_NONE:   o_rdata <= '0;
      endcase
    end
    else
      o_rdata <= '0;

  // RL14 flags hold until cleared
  // RL15 overrun clear on read
  event_flag_bank #(
    .W     (16),
    .VALID (VALID)
  ) u_flags (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_set      (set_vec),
    .i_wr       (wr_flags),
    .i_wdata    (i_wdata),
    .i_rd_clear (i_data_buffer_read),
    .o_flags    (flags)
  );

  // RL2 RL3 RL4 RL5 RL6 RL7 per-bit and
  // RL8 RL9 RL10 RL11 RL12 per-bit and
  // RL16 single level request
  // RL17 enable effect one cycle after the write
  irq_request_gate #(
    .W (16)
  ) u_gate (
    .i_flags  (flags),
    .i_enable (irq_en),
    .o_irq    (o_irq)
  );

  assign o_flags      = flags;
  assign o_irq_enable = irq_en;

  // checks
  property p_enable_reset;
    @(posedge i_ref_clk) i_rst |=> (irq_en == 16'h0000 && !o_irq);
  endproperty
  a_enable_reset: assert property (p_enable_reset) // RL1
    else $error("enable not zero after reset");

  property p_enable_write;
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_enable ##1 (i_rd && decode(i_addr) == SEL_ENABLE)
      |=> (o_rdata == ($past(i_wdata, 2) & 16'h0bff));
  endproperty
  a_enable_write: assert property (p_enable_write) // RL1
    else $error("enable readback differs from write");

  property p_reserved_zero;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && decode(i_addr) == SEL_ENABLE) |=> (o_rdata[15:12] == 4'h0 && !o_rdata[10]);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RL13
    else $error("reserved enable bit reads one");

  property p_gate_start;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags == 16'h0001) |-> (o_irq == irq_en[0]);
  endproperty
  a_gate_start: assert property (p_gate_start) // RL2
    else $error("start gating wrong");

  property p_gate_tx;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags == 16'h0002) |-> (o_irq == irq_en[1]);
  endproperty
  a_gate_tx: assert property (p_gate_tx) // RL3
    else $error("tx done gating wrong");

  property p_gate_rx;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags == 16'h0004) |-> (o_irq == irq_en[2]);
  endproperty
  a_gate_rx: assert property (p_gate_rx) // RL4
    else $error("rx ready gating wrong");

  property p_gate_stretch;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags == 16'h0008) |-> (o_irq == irq_en[3]);
  endproperty
  a_gate_stretch: assert property (p_gate_stretch) // RL5
    else $error("stretch gating wrong");

  property p_gate_timeout;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags == 16'h0010) |-> (o_irq == irq_en[4]);
  endproperty
  a_gate_timeout: assert property (p_gate_timeout) // RL6
    else $error("timeout gating wrong");

  property p_gate_addr;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags == 16'h0020) |-> (o_irq == irq_en[5]);
  endproperty
  a_gate_addr: assert property (p_gate_addr) // RL7
    else $error("address match gating wrong");

  property p_gate_arb;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags == 16'h0040) |-> (o_irq == irq_en[6]);
  endproperty
  a_gate_arb: assert property (p_gate_arb) // RL8
    else $error("arbitration loss gating wrong");

  property p_gate_nack;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags == 16'h0080) |-> (o_irq == irq_en[7]);
  endproperty
  a_gate_nack: assert property (p_gate_nack) // RL9
    else $error("nack gating wrong");

  property p_gate_gencall;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags == 16'h0100) |-> (o_irq == irq_en[8]);
  endproperty
  a_gate_gencall: assert property (p_gate_gencall) // RL10
    else $error("general call gating wrong");

  property p_gencall_blocked;
    @(posedge i_ref_clk) disable iff (i_rst)
    (!flags[8] && !i_gencall_recognize_en && !wr_flags) |=> !flags[8];
  endproperty
  a_gencall_blocked: assert property (p_gencall_blocked) // RL10
    else $error("general call set while recognition off");

  property p_gate_overrun;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags == 16'h0200) |-> (o_irq == irq_en[9]);
  endproperty
  a_gate_overrun: assert property (p_gate_overrun) // RL11
    else $error("overrun gating wrong");

  property p_gate_stop;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags == 16'h0800) |-> (o_irq == irq_en[11]);
  endproperty
  a_gate_stop: assert property (p_gate_stop) // RL12
    else $error("stop gating wrong");

  property p_flag_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags[0] && !wr_flags) |=> flags[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) // RL14
    else $error("flag dropped without software clear");

  property p_set_wins;
    @(posedge i_ref_clk) disable iff (i_rst)
    (set_vec[1] && wr_flags && !i_wdata[1]) |=> flags[1];
  endproperty
  a_set_wins: assert property (p_set_wins) // RL14
    else $error("event lost against clear");

  property p_overrun_read_clear;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_data_buffer_read && !set_vec[9] && !(wr_flags && i_wdata[9])) |=> !flags[9];
  endproperty
  a_overrun_read_clear: assert property (p_overrun_read_clear) // RL15
    else $error("buffer read left overrun set");

  property p_overrun_write_zero;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags[9] && wr_flags && !i_wdata[9] && !i_data_buffer_read) |=> flags[9];
  endproperty
  a_overrun_write_zero: assert property (p_overrun_write_zero) // RL15
    else $error("write of zero cleared overrun");

  property p_irq_cause;
    @(posedge i_ref_clk) disable iff (i_rst)
    o_irq |-> ((flags & irq_en) != 16'h0000) ##0 (flags != 16'h0000);
  endproperty
  a_irq_cause: assert property (p_irq_cause) // RL16
    else $error("request without enabled flag");

  property p_enable_takes_effect;
    @(posedge i_ref_clk) disable iff (i_rst)
    (wr_enable && ((i_wdata & flags & 16'h0bff) != 16'h0000)
      && !i_data_buffer_read && !wr_flags) |=> o_irq;
  endproperty
  a_enable_takes_effect: assert property (p_enable_takes_effect) // RL17
    else $error("enable write did not raise request");

  property p_disable_takes_effect;
    @(posedge i_ref_clk) disable iff (i_rst)
    (wr_enable && i_wdata == 16'h0000) |=> !o_irq;
  endproperty
  a_disable_takes_effect: assert property (p_disable_takes_effect) // RL17
    else $error("request stayed after enables cleared");

  property p_rdata_idle;
    @(posedge i_ref_clk) disable iff (i_rst)
    !i_rd |=> (o_rdata == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // RL1
    else $error("read data stood without a read");

  property p_enable_reserved;
    @(posedge i_ref_clk) disable iff (i_rst)
    (irq_en & 16'hf400) == 16'h0000;
  endproperty
  a_enable_reserved: assert property (p_enable_reserved) // RL13
    else $error("reserved enable bit held one");

  property p_start_set;
    @(posedge i_ref_clk) disable iff (i_rst)
    i_event_set[0] |=> flags[0];
  endproperty
  a_start_set: assert property (p_start_set) // RL2
    else $error("start event not latched");

  property p_gencall_pass;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_event_set[8] && i_gencall_recognize_en) |=> flags[8];
  endproperty
  a_gencall_pass: assert property (p_gencall_pass) // RL10
    else $error("general call lost while recognition on");

  // a set pulse must land even against a buffer read
  property p_overrun_set;
    @(posedge i_ref_clk) disable iff (i_rst)
    i_event_set[9] |=> flags[9];
  endproperty
  a_overrun_set: assert property (p_overrun_set) // RL11
    else $error("overrun event not latched");

  property p_stop_set;
    @(posedge i_ref_clk) disable iff (i_rst)
    i_event_set[11] |=> flags[11];
  endproperty
  a_stop_set: assert property (p_stop_set) // RL12
    else $error("stop event not latched");

  property p_cov_irq_rise;
    @(posedge i_ref_clk) disable iff (i_rst)
    !o_irq ##1 o_irq;
  endproperty
  c_irq_rise: cover property (p_cov_irq_rise);

  property p_cov_overrun_clear;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags[9] && i_data_buffer_read) ##1 !flags[9];
  endproperty
  c_overrun_clear: cover property (p_cov_overrun_clear);

  property p_cov_late_enable;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flags != 16'h0000 && !o_irq && wr_enable) ##1 o_irq;
  endproperty
  c_late_enable: cover property (p_cov_late_enable);

  property p_cov_sw_clear;
    @(posedge i_ref_clk) disable iff (i_rst)
    (o_irq && wr_flags) ##1 !o_irq;
  endproperty
  c_sw_clear: cover property (p_cov_sw_clear);

endmodule // i2c_interrupt_enable_gating
`default_nettype wire

// ### cpu_irq_sink.sv
/*
  cpu side model: takes the level interrupt request and counts its
  rising edges. assumes the same clock and reset as the block.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_irq_sink (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // request from the block
  input  wire logic       i_irq,
  // observed activity
  output var  logic [7:0] o_rise_count
);
  logic irq_q;

  // level request, one count per rise
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      irq_q        <= 1'b0;
      o_rise_count <= 8'h00;
    end
    else
    begin
      irq_q <= i_irq;
      if (i_irq && !irq_q)
      begin
        o_rise_count <= o_rise_count + 8'h01;
      end
    end
  end
endmodule // cpu_irq_sink

`default_nettype wire

// ### i2c_interrupt_enable_gating_tb_top.sv
/*
  self-checking bench for the i2c interrupt gating block.
  assumes one 40 mhz clock and the plain register port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "i2c_irq_map.svh"

module i2c_interrupt_enable_gating_tb_top;
  import i2c_irq_pkg::*;

  logic       i_ref_clk = 1'b0;
  logic       i_rst     = 1'b1;
  addr_t      i_addr    = 8'h00;
  word_t      i_wdata   = 16'h0000;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  word_t      i_event_set = 16'h0000;
  logic       i_gc_en   = 1'b0;
  logic       i_buf_rd  = 1'b0;
  word_t      o_rdata;
  word_t      o_flags;
  word_t      o_irq_enable;
  logic       o_irq;
  logic [7:0] rise_count;
  int         bad_count = 0;
  int         tests_run = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  i2c_interrupt_enable_gating u_i2c_interrupt_enable_gating (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_event_set(i_event_set),
    .i_gencall_recognize_en(i_gc_en), .i_data_buffer_read(i_buf_rd),
    .o_flags(o_flags), .o_irq_enable(o_irq_enable), .o_irq(o_irq)
  );

  cpu_irq_sink u_cpu_irq_sink (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_irq(o_irq), .o_rise_count(rise_count)
  );

  task automatic check(input string what, input word_t exp, input word_t got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input addr_t a, input word_t d);
    @(posedge i_ref_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input addr_t a, output word_t d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // write then read with no gap between the strobes
  task automatic reg_wr_rd(input addr_t a, input word_t wd, output word_t rd);
    @(posedge i_ref_clk);
    i_addr  <= a;
    i_wdata <= wd;
    i_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
    i_rd    <= 1'b1;
    @(posedge i_ref_clk);
    i_rd    <= 1'b0;
    #1;
    rd = o_rdata;
  endtask

  task automatic pulse(input word_t m, input logic buf_rd);
    @(posedge i_ref_clk);
    i_event_set <= m;
    i_buf_rd    <= buf_rd;
    @(posedge i_ref_clk);
    i_event_set <= 16'h0000;
    i_buf_rd    <= 1'b0;
    #1;
  endtask

  task automatic irq_is(input logic e);
    check("o_irq", {15'h0000, e}, {15'h0000, o_irq});
  endtask

  task automatic t_reset_regs;
    word_t d;
    reg_rd(`I2C_IRQ_ENABLE_OFS, d);
    check("enable after reset", 16'h0000, d);
    reg_wr(`I2C_IRQ_ENABLE_OFS, 16'hffff);
    reg_rd(`I2C_IRQ_ENABLE_OFS, d);
    check("enable readback", 16'h0bff, d);
    @(posedge i_ref_clk);
    #1;
    check("rdata after read", 16'h0000, o_rdata);
    reg_wr(8'h7e, 16'hffff);
    reg_rd(8'h7e, d);
    check("unmapped read", 16'h0000, d);
    reg_wr_rd(`I2C_IRQ_ENABLE_OFS, 16'ha5a5, d);
    check("enable back to back", 16'h01a5, d);
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    check("enable after second reset", 16'h0000, o_irq_enable);
    irq_is(1'b0);
  endtask

  // bits 0-9 and 11; others stay quiet
  task automatic t_gating;
    int    bits [11] = '{`BIT_START, `BIT_TX_DONE, `BIT_RX_READY, `BIT_STRETCH,
                         `BIT_TIMEOUT, `BIT_ADDR_MATCH, `BIT_ARB_LOST, `BIT_NACK,
                         `BIT_GENCALL, `BIT_OVERRUN, `BIT_STOP};
    word_t m;
    i_gc_en <= 1'b1;
    foreach (bits[k])
    begin
      m = 16'h0001 << bits[k];
      reg_wr(`I2C_IRQ_ENABLE_OFS, 16'h0000);
      pulse(m, 1'b0);
      check("flag set", m, o_flags);
      irq_is(1'b0);
      reg_wr(`I2C_IRQ_ENABLE_OFS, m);
      irq_is(1'b1);
      // other enables only: the and is per position
      reg_wr(`I2C_IRQ_ENABLE_OFS, ~m & 16'h0bff);
      irq_is(1'b0);
      reg_wr(`I2C_FLAGS_OFS, 16'h0000);
      pulse(16'h0000, 1'b1);
      check("flag cleared", 16'h0000, o_flags);
      reg_wr(`I2C_IRQ_ENABLE_OFS, m);
      irq_is(1'b0);
    end
    reg_wr(`I2C_IRQ_ENABLE_OFS, 16'h0000);
  endtask

  task automatic t_gencall_off;
    i_gc_en <= 1'b0;
    reg_wr(`I2C_IRQ_ENABLE_OFS, 16'h0100);
    pulse(16'h0100, 1'b0);
    check("gencall ignored", 16'h0000, o_flags);
    irq_is(1'b0);
    pulse(16'hf400, 1'b0);
    check("reserved events", 16'h0000, o_flags);
  endtask

  task automatic t_overrun;
    word_t d;
    reg_wr(`I2C_IRQ_ENABLE_OFS, 16'h0200);
    pulse(16'h0200, 1'b0);
    irq_is(1'b1);
    reg_wr(`I2C_FLAGS_OFS, 16'h0000);
    check("overrun after write 0", 16'h0200, o_flags);
    reg_rd(`I2C_FLAGS_OFS, d);
    check("flags read", 16'h0200, d);
    irq_is(1'b1);
    pulse(16'h0000, 1'b1);
    check("overrun after buffer read", 16'h0000, o_flags);
    irq_is(1'b0);
    reg_wr(`I2C_IRQ_ENABLE_OFS, 16'h0000);
  endtask

  // event and clear in one cycle: the event must win
  task automatic t_set_wins;
    @(posedge i_ref_clk);
    i_addr      <= `I2C_FLAGS_OFS;
    i_wdata     <= 16'h0000;
    i_wr        <= 1'b1;
    i_event_set <= 16'h0202;
    i_buf_rd    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr        <= 1'b0;
    i_event_set <= 16'h0000;
    i_buf_rd    <= 1'b0;
    #1;
    check("set against clear", 16'h0202, o_flags);
    reg_wr(`I2C_FLAGS_OFS, 16'h0000);
    pulse(16'h0000, 1'b1);
    check("flags after clears", 16'h0000, o_flags);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_reset_regs();
    t_gating();
    t_gencall_off();
    t_overrun();
    t_set_wins();
    // one rise per gated bit plus the overrun case
    check("cpu rise count", 16'h000c, {8'h00, rise_count});
    final_report();
  end

  // hang guard well past the sequence length
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    final_report();
  end
endmodule // i2c_interrupt_enable_gating_tb_top

`default_nettype wire
